// ---- rtl/bodec_pkg.sv ----
// Package: register map, option byte fields and reset values for the option byte decoder
package bodec_pkg;
  localparam logic [7:0]  OPT_BYTE_ADDR   = 8'h08;
  localparam logic [31:0] REG_OPTION_OFS  = 32'h0000_0008;
  localparam logic [31:0] REG_CTRL_OFS    = 32'h0000_0000;
  localparam logic [31:0] REG_STATUS_OFS  = 32'h0000_0004;
  localparam int          BIT_BUTTON_MODE = 7;
  localparam int          BIT_SCAN        = 6;
  localparam int          BIT_LARGE_PIN   = 5;
  localparam int          BIT_FLOAT       = 4;
  localparam int          BIT_PWR_POL     = 1;
  localparam int          BIT_PWR_EN      = 0;
  localparam logic [7:0]  OPT_RESET       = 8'h00;
  localparam logic [2:0]  BTN_RESET       = 3'h0;
  typedef enum logic [1:0] {
    BODEC_WAIT = 2'b00,
    BODEC_LOAD = 2'b01,
    BODEC_DONE = 2'b10
  } bodec_state_type;
endpackage : bodec_pkg

// ---- rtl/bodec_top.sv ----
// Option byte capture and decode with AHB-Lite register access
//
// Contract
// RL1: Button mode set: pull-up, high-power and power-valid pins read as buttons, bits 2:0.
// RL2: Source keeps button mode zero on small-pin packages.
// RL3: Scan bit one requests post-reset drive scan; zero skips it.
// RL4: Source clears scan bit with only removable drives, sets it otherwise.
// RL5: Pinout select bit: zero small pinout, one large pinout.
// RL6: Float bit one tri-states ATA signals in suspend; zero keeps driving.
// RL7: Source keeps bits 3 and 2 of the option byte zero.
// RL8: Polarity bit: zero power-valid active low, one active high.
// RL9: Enable bit one uses power-valid input, removable drive as master.
// RL10: Option byte captured once after reset, then held until next reset.
module bodec_top (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  output logic             cfg_req,
  output logic      [7:0]  cfg_addr,
  input  wire logic        cfg_valid,
  input  wire logic [7:0]  cfg_data,
  input  wire logic        bus_pullup_enable_pin,
  input  wire logic        high_power_grant_pin,
  input  wire logic        drive_power_valid_pin,
  input  wire logic        usb_suspend,
  output logic             cfg_loaded,
  output logic             post_reset_drive_scan,
  output logic             large_pinout_select,
  output logic             ata_output_enable,
  output logic             button_mode,
  output logic      [2:0]  status_input_endpoint,
  output logic             drive_power_present,
  output logic             removable_drive_enable
);
  bodec_pkg::bodec_state_type state_r;
  logic [7:0]                 option_r;
  logic [2:0]                 pin_s1_r;
  logic [2:0]                 pin_s2_r;
  logic                       susp_s1_r;
  logic                       susp_s2_r;
  logic                       scan_done_r;
  logic                       loaded;
  logic                       take;
  logic                       rd_take;
  logic                       pwr_level;

  // Picks one field of the option byte by its bit position
  function automatic logic opt_bit(input logic [7:0] opt_byte, input int pos);
    return opt_byte[pos];
  endfunction : opt_bit

  // Two-flop synchroniser for the three button-capable pins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_r <= bodec_pkg::BTN_RESET;
      pin_s2_r <= bodec_pkg::BTN_RESET;
    end else begin
      pin_s1_r <= {bus_pullup_enable_pin, high_power_grant_pin, drive_power_valid_pin};
      pin_s2_r <= pin_s1_r;
    end
  end

  // Two-flop synchroniser for the suspend indication
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      susp_s1_r <= 1'b0;
      susp_s2_r <= 1'b0;
    end else begin
      susp_s1_r <= usb_suspend;
      susp_s2_r <= susp_s1_r;
    end
  end

  assign loaded  = (state_r == bodec_pkg::BODEC_DONE);
  assign take    = (state_r == bodec_pkg::BODEC_LOAD) && cfg_valid;
  assign rd_take = hready && hsel && htrans[1] && !hwrite;

  // One-shot load sequence after reset; no way back to the fetch states
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_r <= bodec_pkg::BODEC_WAIT;
    end else begin
      case (state_r)
        bodec_pkg::BODEC_WAIT: begin
          state_r <= bodec_pkg::BODEC_LOAD;
        end
        bodec_pkg::BODEC_LOAD: begin
          if (cfg_valid) begin
            state_r <= bodec_pkg::BODEC_DONE;
          end
        end
        bodec_pkg::BODEC_DONE: begin
          state_r <= bodec_pkg::BODEC_DONE; // [RL10]
        end
        default: begin
          state_r <= bodec_pkg::BODEC_WAIT;
        end
      endcase
    end
  end

  // Fetch request stands from the first edge after reset until the byte arrives
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_req <= 1'b0;
    end else if (state_r == bodec_pkg::BODEC_WAIT) begin
      cfg_req <= 1'b1;
    end else if (state_r != bodec_pkg::BODEC_LOAD || cfg_valid) begin
      cfg_req <= 1'b0;
    end
  end

  // Storage address of the option byte never changes
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_addr <= bodec_pkg::OPT_BYTE_ADDR;
    end else begin
      cfg_addr <= bodec_pkg::OPT_BYTE_ADDR;
    end
  end

  // Option byte is taken once and held until the next reset
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      option_r <= bodec_pkg::OPT_RESET;
    end else if (take) begin
      option_r <= cfg_data; // [RL10]
    end
  end

  // Loaded flag rises together with the decoded settings
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg_loaded <= 1'b0;
    end else if (loaded) begin
      cfg_loaded <= 1'b1; // [RL10]
    end
  end

  // Scan request is a single pulse after load
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      post_reset_drive_scan <= 1'b0;
      scan_done_r           <= 1'b0;
    end else if (loaded) begin
      post_reset_drive_scan <= opt_bit(option_r, bodec_pkg::BIT_SCAN) && !scan_done_r; // [RL3]
      scan_done_r           <= 1'b1;
    end
  end

  // Pinout selection
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      large_pinout_select <= 1'b0;
    end else if (loaded) begin
      large_pinout_select <= opt_bit(option_r, bodec_pkg::BIT_LARGE_PIN); // [RL5]
    end
  end

  // ATA pins float from reset until load, then only while suspended with the float bit set
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ata_output_enable <= 1'b0;
    end else if (loaded) begin
      ata_output_enable <= !(susp_s2_r && opt_bit(option_r, bodec_pkg::BIT_FLOAT)); // [RL6]
    end
  end

  // Button mode flag
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      button_mode <= 1'b0;
    end else if (loaded) begin
      button_mode <= opt_bit(option_r, bodec_pkg::BIT_BUTTON_MODE); // [RL1]
    end
  end

  // Button states reported only in button mode
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_input_endpoint <= bodec_pkg::BTN_RESET;
    end else if (loaded) begin
      status_input_endpoint <= opt_bit(option_r, bodec_pkg::BIT_BUTTON_MODE)
                               ? pin_s2_r : bodec_pkg::BTN_RESET; // [RL1]
    end
  end

  // Removable drive support enable
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      removable_drive_enable <= 1'b0;
    end else if (loaded) begin
      removable_drive_enable <= opt_bit(option_r, bodec_pkg::BIT_PWR_EN); // [RL9]
    end
  end

  // Power-valid level after the configured polarity
  assign pwr_level = opt_bit(option_r, bodec_pkg::BIT_PWR_POL) ? pin_s2_r[0]
                                                               : ~pin_s2_r[0]; // [RL8]

  // Drive power present only when removable support is on
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      drive_power_present <= 1'b0;
    end else if (loaded) begin
      drive_power_present <= opt_bit(option_r, bodec_pkg::BIT_PWR_EN) && pwr_level; // [RL9]
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // Read data is registered in the address phase; writes are ignored
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0000_0000;
    end else if (rd_take) begin
      case ({haddr[31:2], 2'b00})
        bodec_pkg::REG_OPTION_OFS: hrdata <= {24'h00_0000, option_r};
        bodec_pkg::REG_STATUS_OFS: hrdata <= {24'h00_0000, 4'h0, pin_s2_r, cfg_loaded};
        bodec_pkg::REG_CTRL_OFS:   hrdata <= {24'h00_0000, 4'h0, ata_output_enable,
                                              large_pinout_select, removable_drive_enable,
                                              drive_power_present};
        default:                   hrdata <= 32'h0000_0000;
      endcase
    end
  end
endmodule : bodec_top

// ---- bench/bodec_store.sv ----
// Configuration storage model answering one option byte per request
module bodec_store (
  input  wire logic       hclk,
  input  wire logic       cfg_req,
  input  wire logic [7:0] cfg_addr,
  input  wire logic [7:0] opt,
  output logic            cfg_valid,
  output logic      [7:0] cfg_data
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [3:0] wait_r = 4'h0;
  always @(posedge hclk) begin
    wait_r <= cfg_req ? wait_r + 4'h1 : 4'h0;
    cfg_valid <= cfg_req && wait_r == 4'h3;
    // Toggles when idle so a stale byte is never read
    cfg_data <= (cfg_req && wait_r == 4'h3 && cfg_addr == 8'h08) ? opt : ~cfg_data;
  end
endmodule : bodec_store

// ---- bench/bodec_chk.sv ----
// Checker for the option byte decoder ports
module bodec_chk (
  input wire logic       hclk,
  input wire logic       hresetn,
  input wire logic       hreadyout,
  input wire logic       hresp,
  input wire logic       cfg_req,
  input wire logic       cfg_valid,
  input wire logic       usb_suspend,
  input wire logic       cfg_loaded,
  input wire logic       post_reset_drive_scan,
  input wire logic       large_pinout_select,
  input wire logic       ata_output_enable,
  input wire logic       button_mode,
  input wire logic       drive_power_present,
  input wire logic       removable_drive_enable,
  input wire logic [7:0] cfg_addr,
  input wire logic [2:0] status_input_endpoint
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_take; cfg_req && cfg_valid; endsequence
  sequence s_load; !cfg_req ##1 cfg_loaded; endsequence
  property p_take; s_take |=> s_load; endproperty
  a_take: assert property (p_take) else $error("byte load steps wrong");
  property p_hold; cfg_loaded |=> cfg_loaded && $stable(button_mode)
    && $stable(large_pinout_select) && $stable(removable_drive_enable); endproperty
  a_hold: assert property (p_hold) else $error("decoded setting moved");
  property p_early; !cfg_loaded |-> !(button_mode || large_pinout_select); endproperty
  a_early: assert property (p_early) else $error("setting before load");
  property p_btn; !button_mode |-> status_input_endpoint == 3'h0; endproperty
  a_btn: assert property (p_btn) else $error("buttons reported while off");
  property p_rem; !removable_drive_enable |-> !drive_power_present; endproperty
  a_rem: assert property (p_rem) else $error("power valid while disabled");
  property p_scan; post_reset_drive_scan |-> $rose(cfg_loaded) ##1 !post_reset_drive_scan;
  endproperty
  a_scan: assert property (p_scan) else $error("scan request misplaced");
  property p_oe; (!usb_suspend)[*5] ##0 cfg_loaded |-> ata_output_enable; endproperty
  a_oe: assert property (p_oe) else $error("bus released while awake");
  property p_addr; cfg_req |-> cfg_addr == bodec_pkg::OPT_BYTE_ADDR; endproperty
  a_addr: assert property (p_addr) else $error("wrong byte address");
  property p_bus; hreadyout && !hresp; endproperty
  a_bus: assert property (p_bus) else $error("bus not ready or error");
endmodule : bodec_chk
bind bodec_top bodec_chk u_chk (.*);

// ---- bench/tb.sv ----
// Testbench for the option byte decoder
module tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic hclk = '0, hresetn = '0, hsel = '0, hwrite = '0;
  logic [31:0] haddr = '0, hwdata = '0, hrdata, rd;
  logic [1:0]  htrans = '0;
  logic [3:0]  pins = '0;
  logic [7:0]  opt = '0, cfg_addr, cfg_data;
  logic [2:0]  status_input_endpoint;
  logic hreadyout, hresp, cfg_req, cfg_valid, cfg_loaded, post_reset_drive_scan;
  logic large_pinout_select, ata_output_enable, button_mode, drive_power_present;
  logic removable_drive_enable;
  int miscompares = 0, tests_run = 0, scans = 0;
  wire [7:0] dec = {button_mode, large_pinout_select, ata_output_enable,
    removable_drive_enable, drive_power_present, status_input_endpoint};
  always #12.5 hclk = ~hclk;
  always @(posedge hclk) if (post_reset_drive_scan) scans <= scans + 1;
  bodec_top u_dut (.*, .hready(hreadyout), .hsize(3'h2), .usb_suspend(pins[0]),
    .bus_pullup_enable_pin(pins[3]), .high_power_grant_pin(pins[2]),
    .drive_power_valid_pin(pins[1]));
  bodec_store u_store (.*);
  task automatic chk(input logic [31:0] e, g);
    tests_run++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected at %0t: exp %h got %h", $time, e, g);
    end
  endtask : chk
  task automatic bus(input logic w, input logic [31:0] a, d);
    @(posedge hclk);
    hsel <= 1'h1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= a;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'h1);
    rd = hrdata;
  endtask : bus
  task automatic boot(input logic [7:0] b, input logic [3:0] p);
    @(posedge hclk);
    opt = b;
    scans = 0;
    hresetn <= 1'h0;
    pins <= p;
    repeat (16) @(posedge hclk);
    hresetn <= 1'h1;
    repeat (40) if (cfg_loaded !== 1'h1) @(posedge hclk);
    repeat (5) @(posedge hclk);
    chk(32'h1, cfg_loaded);
  endtask : boot
  task automatic t_full;
    boot(8'hf3, 4'hb);
    chk(32'hdd, dec);
    chk(32'h1, scans);
    bus(1'h1, 32'h8, 32'hffff_ffff);
    bus(1'h0, 32'h8, 32'h0);
    chk(32'hf3, rd);
    bus(1'h0, 32'h0, 32'h0);
    chk(32'h7, rd[3:0]);
    bus(1'h0, 32'h4, 32'h0);
    chk(32'hb, rd);
    pins <= 4'h9;
    repeat (5) @(posedge hclk);
    chk(32'hd4, dec);
    $display("t_full done");
  endtask : t_full
  task automatic t_off;
    boot(8'h00, 4'hb);
    chk(32'h20, dec);
    chk(32'h0, scans);
    bus(1'h0, 32'hc, 32'h0);
    chk(32'h0, rd);
    $display("t_off done");
  endtask : t_off
  task automatic t_pol;
    boot(8'h51, 4'h4);
    chk(32'h38, dec);
    chk(32'h1, scans);
    pins <= 4'h3;
    repeat (5) @(posedge hclk);
    chk(32'h10, dec);
    $display("t_pol done");
  endtask : t_pol
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    #50us;
    miscompares++;
    tally_and_finish;
  end
  initial begin
    t_full;
    t_off;
    t_pol;
    tally_and_finish;
  end
endmodule : tb
